// File: hw/uart_lcs_pkg.sv
// Constants for one serial channel: register map, field positions, reset
// values and bit timing.
// Assumes an 8-slot register window reached over a plain strobe port.
package uart_lcs_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [2:0] ADDR_DATA = 3'h0; // Receive/transmit data, divisor low
  localparam logic [2:0] ADDR_IEN = 3'h1; // Interrupt enable, divisor high
  localparam logic [2:0] ADDR_FIFO = 3'h2; // FIFO control / status, enhanced
  localparam logic [2:0] ADDR_LCTL = 3'h3; // line_control
  localparam logic [2:0] ADDR_MCTL = 3'h4; // modem_control
  localparam logic [2:0] ADDR_LSTAT = 3'h5; // line_status
  localparam logic [2:0] ADDR_MSTAT = 3'h6; // Owned by a neighbour, reads zero
  localparam logic [2:0] ADDR_SCRATCH = 3'h7; // Scratch

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int LC_STOP = 2;
  localparam int LC_PEN = 3;
  localparam int LC_EVEN = 4;
  localparam int LC_FORCE = 5;
  localparam int LC_BREAK = 6;
  localparam int LC_DLAB = 7;
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_OUT1 = 2;
  localparam int MC_INTEN = 3;
  localparam int MC_LOOP = 4;
  localparam int MC_XANY = 5;
  localparam int MC_IR = 6;
  localparam int MC_PRESC = 7;
  localparam int IE_RX = 0;
  localparam int IE_TXE = 1;
  localparam int IE_LINE = 2;
  localparam int FC_EN = 0;
  localparam int FC_RXCLR = 1;
  localparam int FC_TXCLR = 2;
  localparam int EF_ARTS = 6;
  localparam int EF_ACTS = 7;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] LCTL_RST = 8'h00;
  localparam logic [7:0] MCTL_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0001;

  // ****************************************************************
  // Bit timing, in sample ticks
  // ****************************************************************
  localparam logic [5:0] TICK_BIT_LAST = 6'h0f; // 16 ticks per bit
  localparam logic [5:0] TICK_HALF_LAST = 6'h07; // Mid start bit
  localparam logic [5:0] TICK_STOP15_LAST = 6'h17; // 1.5 stop bits
  localparam logic [5:0] TICK_STOP2_LAST = 6'h1f; // 2 stop bits
  localparam logic [1:0] PRESC_LAST = 2'h3; // Extra divide by four
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3; // 3/16 bit pulse
  localparam logic [4:0] IR_HOLD_TICKS = 5'h10; // Decoded zero lasts a bit

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_e;

endpackage

// File: hw/uart_lcs.sv
// One asynchronous serial channel: line control, modem control, line
// status, transmit/receive shifters with FIFOs, infrared coding, loopback.
// Assumes the host bus is synchronous to core_clk; serial and modem pins
// are asynchronous and are synchronised here.
//
// The address-and-strobe port and the address map are this design's own decisions.
module uart_lcs #(
  parameter int RX_DEPTH = 128,
  parameter int TX_DEPTH = 128,
  parameter int RTS_LEVEL = 64
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic tx,
  input wire logic rx,
  output logic dtr_n,
  output logic rts_n,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic cd_n,
  output logic user_output_one_n,
  output logic modem_cts,
  output logic modem_dsr,
  output logic modem_ri,
  output logic modem_cd,
  output logic irq_out,
  output logic irq_oe,
  output logic xon_any_resume
);
  import uart_lcs_pkg::*;

  localparam int RAW = $clog2(RX_DEPTH);
  localparam int TAW = $clog2(TX_DEPTH);
  localparam logic [RAW:0] RX_CAP = (RAW + 1)'(RX_DEPTH);
  localparam logic [TAW:0] TX_CAP = (TAW + 1)'(TX_DEPTH);
  localparam logic [RAW:0] RTS_CAP = (RAW + 1)'(RTS_LEVEL);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Keeps only the bits of the selected character length
  function automatic logic [7:0] len_mask(input logic [1:0] len);
    len_mask = 8'hff >> (2'h3 - len);
  endfunction

  // Parity bit for a character under the current line format
  function automatic logic parity_of(input logic [7:0] d, input logic [7:0] lc);
    logic ones;
    ones = ^(d & len_mask(lc[1:0]));
    if (lc[LC_FORCE])
      parity_of = ~lc[LC_EVEN];
    else
      parity_of = lc[LC_EVEN] ? ones : ~ones;
  endfunction

  logic [7:0] line_control_reg;
  logic [7:0] modem_control_reg;
  logic [7:0] ien_reg;
  logic [7:0] scratch_reg;
  logic [7:0] enhanced_feature_register;
  logic [15:0] divisor_reg;
  logic fifo_en_reg;
  logic overrun_reg;
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic dlab;
  logic loop_on;
  logic ir_on;
  logic wr_data_slot;
  logic rd_data_slot;
  logic rd_lstat;
  logic fifo_ctl_wr;

  assign dlab = line_control_reg[LC_DLAB];
  assign loop_on = modem_control_reg[MC_LOOP];
  assign ir_on = modem_control_reg[MC_IR];
  assign wr_data_slot = wr_en && addr == ADDR_DATA && !dlab;
  assign rd_data_slot = rd_en && addr == ADDR_DATA && !dlab;
  assign rd_lstat = rd_en && addr == ADDR_LSTAT;
  assign fifo_ctl_wr = wr_en && addr == ADDR_FIFO && !dlab;

  // ****************************************************************
  // Pin synchronisers: rx, cts, dsr, ri, cd, spare
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sync1_reg <= 6'h3f;
      sync2_reg <= 6'h3f;
    end
    else
    begin
      sync1_reg <= {1'b1, cd_n, ri_n, dsr_n, cts_n, rx};
      sync2_reg <= sync1_reg;
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Divisor and enhanced register share slots with data/enable/FIFO
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      line_control_reg <= LCTL_RST;
      modem_control_reg <= MCTL_RST;
      ien_reg <= 8'h00;
      scratch_reg <= 8'h00;
      enhanced_feature_register <= 8'h00;
      divisor_reg <= DIV_RST;
      fifo_en_reg <= 1'b0;
    end
    else if (wr_en)
    begin
      case (addr)
        ADDR_DATA: if (dlab) divisor_reg[7:0] <= wr_data;
        ADDR_IEN:
          if (dlab)
            divisor_reg[15:8] <= wr_data;
          else
            ien_reg <= wr_data;
        ADDR_FIFO:
          if (dlab)
            enhanced_feature_register <= wr_data;
          else
            fifo_en_reg <= wr_data[FC_EN];
        ADDR_LCTL: line_control_reg <= wr_data;
        ADDR_MCTL: modem_control_reg <= wr_data;
        ADDR_SCRATCH: scratch_reg <= wr_data;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Baud generator
  // ****************************************************************
  // Sample tick = clock / (1 or 4) / divisor; a bit spans 16 ticks
  logic [1:0] presc_reg;
  logic [15:0] div_cnt_reg;
  logic pre_tick;
  logic tick;

  assign pre_tick = !modem_control_reg[MC_PRESC] || presc_reg == PRESC_LAST;
  assign tick = pre_tick && div_cnt_reg <= 16'h0001;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      presc_reg <= 2'h0;
      div_cnt_reg <= DIV_RST;
    end
    else
    begin
      presc_reg <= presc_reg + 2'h1;
      if (tick)
        div_cnt_reg <= divisor_reg;
      else if (pre_tick)
        div_cnt_reg <= div_cnt_reg - 16'h0001;
    end
  end

  // ****************************************************************
  // Transmit FIFO
  // ****************************************************************
  logic [7:0] tx_mem [TX_DEPTH];
  logic [TAW-1:0] tx_wp_reg;
  logic [TAW-1:0] tx_rp_reg;
  logic [TAW:0] tx_cnt_reg;
  logic tx_full;
  logic tx_push;
  logic tx_load;

  // Without FIFO mode the store holds one character
  assign tx_full = fifo_en_reg ? tx_cnt_reg == TX_CAP : tx_cnt_reg != '0;
  assign tx_push = wr_data_slot && !tx_full;

  always_ff @(posedge core_clk)
  begin
    if (tx_push)
      tx_mem[tx_wp_reg] <= wr_data;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || (fifo_ctl_wr && wr_data[FC_TXCLR]))
    begin
      tx_wp_reg <= '0;
      tx_rp_reg <= '0;
      tx_cnt_reg <= '0;
    end
    else
    begin
      if (tx_push)
        tx_wp_reg <= tx_wp_reg + 1'b1;
      if (tx_load)
        tx_rp_reg <= tx_rp_reg + 1'b1;
      tx_cnt_reg <= tx_cnt_reg + (TAW + 1)'(tx_push) - (TAW + 1)'(tx_load);
    end
  end

  // ****************************************************************
  // Transmit shifter
  // ****************************************************************
  tx_state_e tx_state_reg;
  logic [5:0] tx_tick_reg;
  logic [2:0] tx_idx_reg;
  logic [7:0] tx_shift_reg;
  logic tx_par_reg;
  logic tx_line_reg;
  logic cts_active;
  logic tx_serial;
  logic [5:0] tx_last;

  assign cts_active = loop_on ? modem_control_reg[MC_RTS] : ~sync2_reg[1];
  assign tx_load = tick && tx_state_reg == TX_IDLE && tx_cnt_reg != '0 &&
                   !(enhanced_feature_register[EF_ACTS] && !cts_active);
  assign tx_last = tx_state_reg != TX_STOP ? TICK_BIT_LAST :
                   !line_control_reg[LC_STOP] ? TICK_BIT_LAST :
                   line_control_reg[1:0] == 2'h0 ? TICK_STOP15_LAST :
                   TICK_STOP2_LAST;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tx_state_reg <= TX_IDLE;
      tx_tick_reg <= 6'h00;
      tx_idx_reg <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_par_reg <= 1'b0;
      tx_line_reg <= 1'b1;
    end
    else if (tx_load)
    begin
      tx_shift_reg <= tx_mem[tx_rp_reg];
      tx_par_reg <= parity_of(tx_mem[tx_rp_reg], line_control_reg);
      tx_line_reg <= 1'b0;
      tx_tick_reg <= 6'h00;
      tx_state_reg <= TX_START;
    end
    else if (tick)
    begin
      tx_tick_reg <= tx_tick_reg + 6'h01;
      if (tx_state_reg != TX_IDLE && tx_tick_reg == tx_last)
      begin
        tx_tick_reg <= 6'h00;
        case (tx_state_reg)
          TX_START:
          begin
            tx_line_reg <= tx_shift_reg[0];
            tx_idx_reg <= 3'h0;
            tx_state_reg <= TX_DATA;
          end
          TX_DATA:
          begin
            tx_shift_reg <= tx_shift_reg >> 1;
            tx_idx_reg <= tx_idx_reg + 3'h1;
            tx_line_reg <= tx_shift_reg[1];
            if (tx_idx_reg == {1'b1, line_control_reg[1:0]})
            begin
              if (line_control_reg[LC_PEN])
              begin
                tx_line_reg <= tx_par_reg;
                tx_state_reg <= TX_PARITY;
              end
              else
              begin
                tx_line_reg <= 1'b1;
                tx_state_reg <= TX_STOP;
              end
            end
          end
          TX_PARITY:
          begin
            tx_line_reg <= 1'b1;
            tx_state_reg <= TX_STOP;
          end
          default:
            tx_state_reg <= TX_IDLE;
        endcase
      end
    end
  end

  // Break overrides the stream; loopback parks the pin high
  assign tx_serial = tx_line_reg && !line_control_reg[LC_BREAK];

  always_comb
  begin
    if (loop_on)
      tx = 1'b1;
    else if (ir_on)
      tx = !tx_serial && tx_tick_reg[3:0] < IR_PULSE_TICKS;
    else
      tx = tx_serial;
  end

  // ****************************************************************
  // Receive input selection and infrared decoding
  // ****************************************************************
  logic [4:0] ir_hold_reg;
  logic rx_in;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      ir_hold_reg <= 5'h00;
    else if (ir_on && sync2_reg[0])
      ir_hold_reg <= IR_HOLD_TICKS;
    else if (tick && ir_hold_reg != 5'h00)
      ir_hold_reg <= ir_hold_reg - 5'h01;
  end

  assign rx_in = loop_on ? tx_serial : ir_on ? ir_hold_reg == 5'h00 : sync2_reg[0];

  // ****************************************************************
  // Receive shifter
  // ****************************************************************
  rx_state_e rx_state_reg;
  logic [5:0] rx_tick_reg;
  logic [2:0] rx_idx_reg;
  logic [7:0] rx_shift_reg;
  logic rx_pbit_reg;
  logic rx_zero_reg;
  logic brk_wait_reg;
  logic rx_done_reg;
  logic [10:0] rx_word_reg;
  logic [7:0] rx_aligned;

  assign rx_aligned = rx_shift_reg >> (2'h3 - line_control_reg[1:0]);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rx_state_reg <= RX_IDLE;
      rx_tick_reg <= 6'h00;
      rx_idx_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_pbit_reg <= 1'b0;
      rx_zero_reg <= 1'b0;
      brk_wait_reg <= 1'b0;
      rx_done_reg <= 1'b0;
      rx_word_reg <= 11'h000;
    end
    else
    begin
      rx_done_reg <= 1'b0;
      if (tick)
      begin
        rx_tick_reg <= rx_tick_reg + 6'h01;
        case (rx_state_reg)
          RX_IDLE:
          begin
            rx_tick_reg <= 6'h00;
            if (rx_in)
              brk_wait_reg <= 1'b0;
            else if (!brk_wait_reg)
              rx_state_reg <= RX_START;
          end
          RX_START:
            if (rx_tick_reg == TICK_HALF_LAST)
            begin
              rx_tick_reg <= 6'h00;
              rx_idx_reg <= 3'h0;
              rx_zero_reg <= 1'b1;
              rx_state_reg <= rx_in ? RX_IDLE : RX_DATA;
            end
          RX_DATA:
            if (rx_tick_reg == TICK_BIT_LAST)
            begin
              rx_tick_reg <= 6'h00;
              rx_shift_reg <= {rx_in, rx_shift_reg[7:1]};
              rx_zero_reg <= rx_zero_reg && !rx_in;
              rx_idx_reg <= rx_idx_reg + 3'h1;
              if (rx_idx_reg == {1'b1, line_control_reg[1:0]})
                rx_state_reg <= line_control_reg[LC_PEN] ? RX_PARITY : RX_STOP;
            end
          RX_PARITY:
            if (rx_tick_reg == TICK_BIT_LAST)
            begin
              rx_tick_reg <= 6'h00;
              rx_pbit_reg <= rx_in;
              rx_zero_reg <= rx_zero_reg && !rx_in;
              rx_state_reg <= RX_STOP;
            end
          default:
            if (rx_tick_reg == TICK_BIT_LAST)
            begin
              rx_state_reg <= RX_IDLE;
              rx_done_reg <= 1'b1;
              rx_word_reg[7:0] <= rx_aligned;
              rx_word_reg[8] <= line_control_reg[LC_PEN] &&
                rx_pbit_reg != parity_of(rx_aligned, line_control_reg);
              rx_word_reg[9] <= !rx_in;
              rx_word_reg[10] <= rx_zero_reg && !rx_in;
              brk_wait_reg <= rx_zero_reg && !rx_in;
            end
        endcase
      end
    end
  end

  // ****************************************************************
  // Receive FIFO: {break, framing, parity, data}
  // ****************************************************************
  logic [10:0] rx_mem [RX_DEPTH];
  logic [RAW-1:0] rx_wp_reg;
  logic [RAW-1:0] rx_rp_reg;
  logic [RAW:0] rx_cnt_reg;
  logic rx_full;
  logic rx_push;
  logic rx_pop;
  logic [10:0] rx_top;

  assign rx_full = fifo_en_reg ? rx_cnt_reg == RX_CAP : rx_cnt_reg != '0;
  assign rx_push = rx_done_reg && !rx_full;
  assign rx_pop = rd_data_slot && rx_cnt_reg != '0;
  assign rx_top = rx_cnt_reg != '0 ? rx_mem[rx_rp_reg] : 11'h000;

  always_ff @(posedge core_clk)
  begin
    if (rx_push)
      rx_mem[rx_wp_reg] <= rx_word_reg;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || (fifo_ctl_wr && wr_data[FC_RXCLR]))
    begin
      rx_wp_reg <= '0;
      rx_rp_reg <= '0;
      rx_cnt_reg <= '0;
    end
    else
    begin
      if (rx_push)
        rx_wp_reg <= rx_wp_reg + 1'b1;
      if (rx_pop)
        rx_rp_reg <= rx_rp_reg + 1'b1;
      rx_cnt_reg <= rx_cnt_reg + (RAW + 1)'(rx_push) - (RAW + 1)'(rx_pop);
    end
  end

  // Overrun is sticky until line status is read; a new one wins
  always_ff @(posedge core_clk)
  begin
    if (rst)
      overrun_reg <= 1'b0;
    else if (rx_done_reg && rx_full)
      overrun_reg <= 1'b1;
    else if (rd_lstat)
      overrun_reg <= 1'b0;
  end

  // ****************************************************************
  // Line status and read port
  // ****************************************************************
  logic [7:0] line_status;
  logic irq;

  always_comb
  begin
    line_status = 8'h00;
    line_status[0] = rx_cnt_reg != '0;
    line_status[1] = overrun_reg;
    line_status[2] = rx_top[8];
    line_status[3] = rx_top[9];
    line_status[4] = rx_top[10];
    line_status[5] = tx_cnt_reg == '0;
    line_status[6] = tx_cnt_reg == '0 && tx_state_reg == TX_IDLE;
  end

  assign irq = (ien_reg[IE_RX] && line_status[0]) ||
               (ien_reg[IE_TXE] && line_status[5]) ||
               (ien_reg[IE_LINE] && |line_status[4:1]);

  always_ff @(posedge core_clk)
  begin
    if (rst)
      rd_data <= 8'h00;
    else if (rd_en)
    begin
      case (addr)
        ADDR_DATA: rd_data <= dlab ? divisor_reg[7:0] : rx_top[7:0];
        ADDR_IEN: rd_data <= dlab ? divisor_reg[15:8] : ien_reg;
        ADDR_FIFO: rd_data <= dlab ? enhanced_feature_register :
                              {fifo_en_reg, fifo_en_reg, 5'h00, !irq};
        ADDR_LCTL: rd_data <= line_control_reg;
        ADDR_MCTL: rd_data <= modem_control_reg;
        ADDR_LSTAT: rd_data <= line_status;
        ADDR_SCRATCH: rd_data <= scratch_reg;
        default: rd_data <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Modem lines, interrupt pin, resume pulse
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      irq_out <= 1'b0;
      xon_any_resume <= 1'b0;
    end
    else
    begin
      irq_out <= irq;
      xon_any_resume <= rx_push && modem_control_reg[MC_XANY];
    end
  end

  assign irq_oe = modem_control_reg[MC_INTEN];
  assign dtr_n = loop_on || !modem_control_reg[MC_DTR];
  assign rts_n = loop_on ? 1'b1 :
                 enhanced_feature_register[EF_ARTS] ? rx_cnt_reg >= RTS_CAP :
                 !modem_control_reg[MC_RTS];
  assign user_output_one_n = !(loop_on && modem_control_reg[MC_OUT1]);
  assign modem_cts = cts_active;
  assign modem_dsr = loop_on ? modem_control_reg[MC_DTR] : !sync2_reg[2];
  assign modem_ri = loop_on ? modem_control_reg[MC_OUT1] : !sync2_reg[3];
  assign modem_cd = loop_on ? modem_control_reg[MC_INTEN] : !sync2_reg[4];

endmodule

// File: verification/uart_lcs_props.sv
// Port checker for the serial channel block.
// Assumes it is bound to uart_lcs and that auto RTS and auto CTS stay off.
module uart_lcs_props import uart_lcs_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic tx,
  input wire logic dtr_n,
  input wire logic rts_n,
  input wire logic user_output_one_n,
  input wire logic modem_cts,
  input wire logic irq_oe,
  input wire logic xon_any_resume
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mc_wr;
  logic lc_wr;
  // Control register write decodes
  assign mc_wr = wr_en && addr == ADDR_MCTL;
  assign lc_wr = wr_en && addr == ADDR_LCTL;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_dtr_follows: assert property (
    mc_wr && !wr_data[MC_LOOP] |=> dtr_n == !$past(wr_data[MC_DTR]))
    else $error("dtr_n wrong after write");
  a_rts_follows: assert property (
    mc_wr && !wr_data[MC_LOOP] |=> rts_n == !$past(wr_data[MC_RTS]))
    else $error("rts_n wrong after write");
  a_irq_drive: assert property (
    mc_wr |=> irq_oe == $past(wr_data[MC_INTEN]))
    else $error("irq_oe wrong after write");
  a_out_one: assert property (
    mc_wr |=> user_output_one_n == !($past(wr_data[MC_OUT1]) && $past(wr_data[MC_LOOP])))
    else $error("output one wrong");
  a_loop_idle: assert property (
    mc_wr && wr_data[MC_LOOP] && !wr_data[MC_IR] |=> tx && modem_cts == $past(wr_data[MC_RTS]))
    else $error("loopback pins wrong");
  a_break_low: assert property (
    lc_wr && wr_data[LC_BREAK] |=> !tx)
    else $error("tx not low in break");
  a_status_sane: assert property (
    rd_en && addr == ADDR_LSTAT |=> !rd_data[7] && (rd_data[5] || !rd_data[6]))
    else $error("line status inconsistent");
  a_resume_pulse: assert property (
    $rose(xon_any_resume) |=> !xon_any_resume)
    else $error("resume pulse too long");
  // Main scenarios reached
  c_status_read: cover property (rd_en && addr == ADDR_LSTAT);
  c_resume: cover property (xon_any_resume);
  c_loop: cover property (mc_wr && wr_data[MC_LOOP]);
endmodule

// File: verification/uart_lcs_remote.sv
// Remote serial peer: sends frames on rx, decodes frames seen on tx.
// Assumes 16 core clocks per bit; rx idles high like a pulled-up line.
module uart_lcs_remote (
  input wire logic core_clk,
  input wire logic tx,
  output logic rx
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rx = 1'b1;
  // Start, data LSB first, optional parity, stop level, then idle high
  task automatic send(input logic [7:0] d, input int n, input logic pen, input logic p,
    input logic stp);
    logic [11:0] f;
    int len;
    f = {1'b0, stp, p, d, 1'b0} >> (pen ? 8 - n : 9 - n);
    f[n + 1] = pen ? p : stp;
    f[0] = 1'b0;
    len = n + 2 + pen;
    for (int i = 0; i < len; i++)
    begin
      rx <= f[i];
      repeat (16) @(posedge core_clk);
    end
    rx <= 1'b1;
    repeat (40) @(posedge core_clk);
  endtask
  // Line held low longer than a frame, then idle
  task automatic brk(input int bits);
    rx <= 1'b0;
    repeat (bits * 16) @(posedge core_clk);
    rx <= 1'b1;
    repeat (40) @(posedge core_clk);
  endtask
  // Sample start and following bits in mid-bit
  task automatic capture(input int n, output logic [10:0] f);
    f = '0;
    while (tx !== 1'b0) @(posedge core_clk);
    repeat (8) @(posedge core_clk);
    for (int i = 0; i <= n; i++)
    begin
      f[i] = tx;
      repeat (16) @(posedge core_clk);
    end
  endtask
  // Length of the first low stretch in clocks
  task automatic low_len(output int c);
    c = 0;
    while (tx !== 1'b0) @(posedge core_clk);
    while (tx === 1'b0)
    begin
      c++;
      @(posedge core_clk);
    end
  endtask
endmodule

// File: verification/uart_line_modem_control_status_tb.sv
// Self-checking bench for the serial channel block.
// Assumes the package, design, remote peer and checker are compiled first.
module uart_line_modem_control_status_tb import uart_lcs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst = 1, wr_en = 0, rd_en = 0, cts_n = 0;
  logic [2:0] addr = 0;
  logic [7:0] wr_data = 0, rd_data, rd_val, m;
  logic [10:0] fr;
  logic tx, rx, dtr_n, rts_n, op_n, mcts, mdsr, mri, mcd, irq_out, irq_oe, xon;
  logic [7:0] fmt [8] = '{8'h03, 8'h0b, 8'h1b, 8'h2b, 8'h3b, 8'h04, 8'h0d, 8'h1e};
  int miscompares = 0, num_checks = 0, xon_cnt = 0, n, c;
  always #50 core_clk = ~core_clk;
  uart_lcs dut_u (.core_clk(core_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .tx(tx), .rx(rx), .dtr_n(dtr_n),
    .rts_n(rts_n), .cts_n(cts_n), .dsr_n(1'b1), .ri_n(1'b1), .cd_n(1'b1),
    .user_output_one_n(op_n), .modem_cts(mcts), .modem_dsr(mdsr), .modem_ri(mri),
    .modem_cd(mcd), .irq_out(irq_out), .irq_oe(irq_oe), .xon_any_resume(xon));
  uart_lcs_remote remote_u (.core_clk(core_clk), .tx(tx), .rx(rx));
  // Resume pulses seen
  always @(posedge core_clk) if (xon === 1'b1) xon_cnt++;
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(posedge core_clk);
    d = rd_data;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    rd(a, rd_val);
    chk(rd_val, exp);
  endtask
  task automatic final_report;
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog: about 20 frames of under 1 ms in all, so 4 ms is ample
  initial
  begin
    #4000000;
    miscompares++;
    final_report();
  end
  // Main sequence
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rdc(ADDR_LSTAT, 8'h60);
    rdc(ADDR_LCTL, LCTL_RST);
    wr(ADDR_LCTL, 8'h83);
    wr(ADDR_DATA, 8'h01);
    rdc(ADDR_DATA, 8'h01);
    wr(ADDR_LCTL, 8'h03);
    rdc(ADDR_DATA, 8'h00);
    foreach (fmt[i])
    begin
      n = fmt[i][1:0] + 5;
      m = 8'hff >> (8 - n);
      wr(ADDR_LCTL, fmt[i]);
      wr(ADDR_DATA, 8'ha5);
      rdc(ADDR_LSTAT, 8'h20);
      remote_u.capture(n + 2, fr);
      chk(fr[8:1] & m, 8'ha5 & m);
      c = fmt[i][LC_FORCE] ? !fmt[i][LC_EVEN] : fmt[i][LC_EVEN] ? ^(8'ha5 & m) : ~^(8'ha5 & m);
      chk({7'h0, fr[n + 1]}, fmt[i][LC_PEN] ? 8'(c) : 8'h01);
      repeat (40) @(posedge core_clk);
      rdc(ADDR_LSTAT, 8'h60);
    end
    wr(ADDR_LCTL, 8'h03);
    for (int k = 0; k < 2; k++)
    begin
      wr(ADDR_MCTL, {k[0], 7'h0});
      wr(ADDR_DATA, 8'hff);
      remote_u.low_len(c);
      chk(8'(c), 8'(16 << (2 * k)));
      repeat (700) @(posedge core_clk);
    end
    wr(ADDR_LCTL, 8'h43);
    chk({7'h0, tx}, 8'h00);
    wr(ADDR_LCTL, 8'h03);
    chk({7'h0, tx}, 8'h01);
    wr(ADDR_MCTL, 8'h40);
    repeat (4) @(posedge core_clk);
    chk({7'h0, tx}, 8'h00);
    wr(ADDR_LCTL, 8'h1b);
    wr(ADDR_MCTL, 8'h20);
    remote_u.send(8'h3c, 8, 1'b1, 1'b0, 1'b1);
    rdc(ADDR_LSTAT, 8'h61);
    rdc(ADDR_DATA, 8'h3c);
    rdc(ADDR_LSTAT, 8'h60);
    remote_u.send(8'h3c, 8, 1'b1, 1'b1, 1'b1);
    rdc(ADDR_LSTAT, 8'h65);
    rdc(ADDR_DATA, 8'h3c);
    remote_u.send(8'h3c, 8, 1'b1, 1'b0, 1'b0);
    rdc(ADDR_LSTAT, 8'h69);
    rdc(ADDR_DATA, 8'h3c);
    remote_u.brk(14);
    rd(ADDR_LSTAT, rd_val);
    chk(rd_val & 8'h11, 8'h11);
    rdc(ADDR_DATA, 8'h00);
    rdc(ADDR_LSTAT, 8'h60);
    remote_u.send(8'h11, 8, 1'b1, 1'b0, 1'b1);
    remote_u.send(8'h22, 8, 1'b1, 1'b0, 1'b1);
    rdc(ADDR_LSTAT, 8'h63);
    rdc(ADDR_DATA, 8'h11);
    rdc(ADDR_LSTAT, 8'h60);
    chk(8'(xon_cnt), 8'h05);
    // FIFO mode: both characters kept, error flags follow the top entry
    wr(ADDR_FIFO, 8'h01);
    remote_u.send(8'h11, 8, 1'b1, 1'b0, 1'b1);
    remote_u.send(8'h22, 8, 1'b1, 1'b1, 1'b1);
    rdc(ADDR_LSTAT, 8'h61);
    rdc(ADDR_DATA, 8'h11);
    rdc(ADDR_LSTAT, 8'h65);
    rdc(ADDR_DATA, 8'h22);
    wr(ADDR_MCTL, 8'h17);
    wr(ADDR_DATA, 8'h5a);
    repeat (400) @(posedge core_clk);
    chk({4'h0, tx, dtr_n, rts_n, op_n}, 8'h0e);
    chk({4'h0, mcts, mdsr, mri, mcd}, 8'h0e);
    rdc(ADDR_DATA, 8'h5a);
    wr(ADDR_MCTL, 8'h0b);
    chk({3'h0, dtr_n, rts_n, irq_oe, mcts, mdsr}, 8'h06);
    // Holding empty raises the registered request only while enabled
    wr(ADDR_IEN, 8'h02);
    @(posedge core_clk);
    chk({7'h0, irq_out}, 8'h01);
    wr(ADDR_IEN, 8'h00);
    @(posedge core_clk);
    chk({7'h0, irq_out}, 8'h00);
    final_report();
  end
endmodule
bind uart_lcs uart_lcs_props chk_u (.core_clk(core_clk), .rst(rst), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .tx(tx),
  .dtr_n(dtr_n), .rts_n(rts_n), .user_output_one_n(user_output_one_n),
  .modem_cts(modem_cts), .irq_oe(irq_oe), .xon_any_resume(xon_any_resume));
